// File: core/gpcp_port.sv
// The register addresses and the Avalon-MM slave port were left to the implementer.
`default_nettype none
// ----------------------------------------
// ----------------------------------------
module gpcp_port
#(
	parameter bit ANALOG = 1'b0
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic [gpcp_pkg::ADDR_W-1:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output logic [31:0] avs_readdata,
	output logic avs_readdatavalid,
	output logic [1:0] avs_response,
	output logic avs_waitrequest,
	input wire logic [gpcp_pkg::PINS*gpcp_pkg::SEL_W*2-1:0] periph_out,
	input wire logic [gpcp_pkg::PINS*gpcp_pkg::SEL_W*2-1:0] periph_oe,
	input wire logic [gpcp_pkg::PINS-1:0] pad_in,
	output logic [gpcp_pkg::PINS-1:0] pad_out,
	output logic [gpcp_pkg::PINS-1:0] pad_oe,
	output logic [gpcp_pkg::PINS-1:0] pad_strength,
	output logic [gpcp_pkg::PINS-1:0] pad_high_bias,
	output logic [gpcp_pkg::PINS-1:0] pad_low_bias
);
	import gpcp_pkg::*;
	typedef struct packed {
		logic [PINS-1:0] out_value;
		logic [PINS-1:0] drive_enable;
		logic [PINS-1:0] strength_select;
		logic [PINS-1:0] weak_high_bias;
		logic [PINS-1:0] weak_low_bias;
		logic [PINS-1:0] receive_gate;
		logic [PINS*SEL_W-1:0] func_select;
		logic ack;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] resp;
	} gpcp_port_t;
	gpcp_port_t state;
	gpcp_port_t next_state;
	logic [PINS-1:0] level;
	logic [PINS-1:0] func_active;
	logic [PINS-1:0] sel_out;
	logic [PINS-1:0] sel_oe;
	// ----------------------------------------
	// Byte-lane write of a per-pin register
	// ----------------------------------------
	function automatic logic [PINS-1:0] lane0(input logic [PINS-1:0] old,
		input logic [31:0] wd, input logic [3:0] be);
		lane0 = be[0] ? wd[PINS-1:0] : old;
	endfunction
	logic req;
	logic mapped;
	assign req = (avs_read || avs_write) && !state.ack;
	always_comb begin
		case (avs_address)
			OFS_OUT_VALUE, OFS_DRIVE_ENABLE, OFS_PIN_LEVEL: mapped = 1'b1;
			OFS_RECEIVE_GATE: mapped = ANALOG;
			OFS_STRENGTH, OFS_HIGH_BIAS, OFS_LOW_BIAS, OFS_FUNC_SELECT: mapped = !ANALOG;
			default: mapped = 1'b0;
		endcase
	end
	always_comb begin
		next_state = state;
		next_state.ack = req;
		next_state.rvalid = req && avs_read;
		next_state.resp = mapped ? RESP_OKAY : RESP_DECODEERROR;
		next_state.rdata = UNMAPPED_DATA;
		if (req && avs_write && mapped) begin
			case (avs_address)
				OFS_OUT_VALUE: next_state.out_value =
					lane0(state.out_value, avs_writedata, avs_byteenable);
				OFS_DRIVE_ENABLE: next_state.drive_enable =
					lane0(state.drive_enable, avs_writedata, avs_byteenable);
				OFS_STRENGTH: next_state.strength_select =
					lane0(state.strength_select, avs_writedata, avs_byteenable);
				OFS_HIGH_BIAS: next_state.weak_high_bias =
					lane0(state.weak_high_bias, avs_writedata, avs_byteenable);
				OFS_LOW_BIAS: next_state.weak_low_bias =
					lane0(state.weak_low_bias, avs_writedata, avs_byteenable);
				OFS_RECEIVE_GATE: next_state.receive_gate =
					lane0(state.receive_gate, avs_writedata, avs_byteenable);
				OFS_FUNC_SELECT: begin
					if (avs_byteenable[0]) begin
						next_state.func_select[7:0] = avs_writedata[7:0];
					end
					if (avs_byteenable[1]) begin
						next_state.func_select[15:8] = avs_writedata[15:8];
					end
				end
				default: next_state.rdata = UNMAPPED_DATA;
			endcase
		end
		if (req && avs_read && mapped) begin
			case (avs_address)
				OFS_OUT_VALUE: next_state.rdata = {24'h000000, state.out_value};
				OFS_DRIVE_ENABLE: next_state.rdata = {24'h000000, state.drive_enable};
				OFS_STRENGTH: next_state.rdata = {24'h000000, state.strength_select};
				OFS_HIGH_BIAS: next_state.rdata = {24'h000000, state.weak_high_bias};
				OFS_LOW_BIAS: next_state.rdata = {24'h000000, state.weak_low_bias};
				OFS_PIN_LEVEL: next_state.rdata = {24'h000000, level};
				OFS_RECEIVE_GATE: next_state.rdata = {24'h000000, state.receive_gate};
				OFS_FUNC_SELECT: next_state.rdata = {16'h0000, state.func_select};
				default: next_state.rdata = UNMAPPED_DATA;
			endcase
		end
		// Analog port has no such storage; keep it constant
		if (ANALOG) begin
			next_state.strength_select = RST_BYTE;
			next_state.weak_high_bias = RST_BYTE;
			next_state.weak_low_bias = RST_BYTE;
			next_state.func_select = RST_FSEL;
		end else begin
			next_state.receive_gate = RST_GATE;
		end
	end
	always_ff @(posedge clk) begin
		if (rst) begin
			state.out_value <= RST_BYTE;
			state.drive_enable <= RST_BYTE;
			state.strength_select <= RST_BYTE;
			state.weak_high_bias <= RST_BYTE;
			state.weak_low_bias <= RST_BYTE;
			state.receive_gate <= ANALOG ? RST_BYTE : RST_GATE;
			state.func_select <= RST_FSEL;
			state.ack <= 1'b0;
			state.rvalid <= 1'b0;
			state.rdata <= UNMAPPED_DATA;
			state.resp <= RESP_OKAY;
		end else begin
			state <= next_state;
		end
	end
	// Answer one cycle after the request; waitrequest drops combinationally on ack
	assign avs_waitrequest = (avs_read || avs_write) && !state.ack;
	assign avs_readdata = state.rdata;
	assign avs_readdatavalid = state.rvalid;
	assign avs_response = state.resp;
	// ----------------------------------------
	// Pins
	// ----------------------------------------
	// Slot k-1 of a pin's field feeds peripheral k; the top slot stays spare
	// Select 0 returns 0 so no slot index ever leaves the bus
	function automatic logic pick(input logic [PINS*SEL_W*2-1:0] v, input int pin,
		input logic [SEL_W-1:0] sel);
		pick = 1'b0;
		if (sel != '0) begin
			pick = v[pin*SEL_W*2 + int'(sel) - 1];
		end
	endfunction
	always_comb begin
		for (int i = 0; i < PINS; i++) begin
			func_active[i] = state.func_select[i*SEL_W +: SEL_W] != '0;
			sel_out[i] = pick(periph_out, i, state.func_select[i*SEL_W +: SEL_W]);
			sel_oe[i] = pick(periph_oe, i, state.func_select[i*SEL_W +: SEL_W]);
		end
	end
	genvar g;
	generate
		for (g = 0; g < PINS; g++) begin : g_pin
			gpcp_pin_cell #(.ANALOG(ANALOG)) u_cell (
				.clk(clk),
				.rst(rst),
				.out_value(state.out_value[g]),
				.drive_enable(state.drive_enable[g]),
				.func_active(func_active[g]),
				.periph_out(sel_out[g]),
				.periph_oe(sel_oe[g]),
				.receive_gate(state.receive_gate[g]),
				.pad_in(pad_in[g]),
				.pad_out(pad_out[g]),
				.pad_oe(pad_oe[g]),
				.level(level[g])
			);
		end
	endgenerate
	// Strength only reaches the pad while the pad is driven
	assign pad_strength = state.strength_select & pad_oe;
	assign pad_high_bias = state.weak_high_bias;
	assign pad_low_bias = state.weak_low_bias;
	// ----------------------------------------
	// Checks
	// ----------------------------------------
	chk_reset_all_zero: assert property (@(posedge clk) rst |=>
		pad_oe == '0 && pad_out == '0 && pad_strength == '0 && pad_high_bias == '0
		&& pad_low_bias == '0 && state.func_select == '0)
		else $error("controls not zero after reset");
	chk_level_tracks_pad: assert property (@(posedge clk) disable iff (rst)
		!ANALOG && !$past(rst) |-> level == $past(pad_in))
		else $error("level register does not track pad");
	chk_gate_masks_level: assert property (@(posedge clk) disable iff (rst)
		ANALOG && !$past(rst) |-> level == $past(pad_in & state.receive_gate))
		else $error("gated level does not follow pad");
	chk_level_read: assert property (@(posedge clk) disable iff (rst)
		$past(req && avs_read && avs_address == OFS_PIN_LEVEL) |-> avs_readdata == {24'h000000, $past(level)})
		else $error("level read returns stale data");
	chk_analog_no_extras: assert property (@(posedge clk) disable iff (rst)
		ANALOG |-> pad_strength == '0 && pad_low_bias == '0 && pad_high_bias == '0
		&& state.func_select == '0)
		else $error("analog port has extra controls");
	chk_write_byte: assert property (@(posedge clk) disable iff (rst)
		req && avs_write && avs_address == OFS_DRIVE_ENABLE && avs_byteenable[0]
		|=> state.drive_enable == $past(avs_writedata[7:0]))
		else $error("byte write not taken");
endmodule
`default_nettype wire

// File: core/gpcp_pkg.sv
`default_nettype none
package gpcp_pkg;
	localparam int PINS = 8;
	localparam int SEL_W = 2;
	localparam int ADDR_W = 6;
	// Register byte addresses
	localparam logic [ADDR_W-1:0] OFS_OUT_VALUE = 6'h00;
	localparam logic [ADDR_W-1:0] OFS_DRIVE_ENABLE = 6'h04;
	localparam logic [ADDR_W-1:0] OFS_STRENGTH = 6'h08;
	localparam logic [ADDR_W-1:0] OFS_HIGH_BIAS = 6'h0C;
	localparam logic [ADDR_W-1:0] OFS_LOW_BIAS = 6'h10;
	localparam logic [ADDR_W-1:0] OFS_PIN_LEVEL = 6'h14;
	localparam logic [ADDR_W-1:0] OFS_RECEIVE_GATE = 6'h18;
	localparam logic [ADDR_W-1:0] OFS_FUNC_SELECT = 6'h1C;
	// Reset values and bus response codes
	localparam logic [7:0] RST_BYTE = 8'h00;
	localparam logic [7:0] RST_GATE = 8'hFF;
	localparam logic [15:0] RST_FSEL = 16'h0000;
	localparam logic [31:0] UNMAPPED_DATA = 32'h00000000;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_DECODEERROR = 2'h3;
endpackage
`default_nettype wire

// File: core/gpcp_pin_cell.sv
`default_nettype none
// ----------------------------------------
// Per-pin output and input path
// ----------------------------------------
module gpcp_pin_cell #(
	parameter bit ANALOG = 1'b0
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic out_value,
	input wire logic drive_enable,
	input wire logic func_active,
	input wire logic periph_out,
	input wire logic periph_oe,
	input wire logic receive_gate,
	input wire logic pad_in,
	output logic pad_out,
	output logic pad_oe,
	output logic level
);
	typedef struct packed {
		logic out;
		logic oe;
		logic lvl;
	} gpcp_cell_t;
	gpcp_cell_t state;
	gpcp_cell_t next_state;
	always_comb begin
		next_state = state;
		if (func_active && !ANALOG) begin
			next_state.out = periph_out;
			next_state.oe = periph_oe;
		end else begin
			next_state.out = out_value;
			next_state.oe = drive_enable;
		end
		// Gated input reads 0 so a floating analog node costs no power
		next_state.lvl = ANALOG ? (pad_in & receive_gate) : pad_in;
	end
	always_ff @(posedge clk) begin
		if (rst) begin
			state <= '0;
		end else begin
			state <= next_state;
		end
	end
	assign pad_out = state.out;
	assign pad_oe = state.oe;
	assign level = state.lvl;
	chk_drive_follows_value: assert property (@(posedge clk) disable iff (rst)
		$past(drive_enable) && !$past(func_active) |-> pad_oe && pad_out == $past(out_value))
		else $error("pin does not drive output value");
	chk_periph_routes: assert property (@(posedge clk) disable iff (rst)
		$past(func_active) |-> pad_oe == $past(periph_oe) && pad_out == $past(periph_out))
		else $error("pin does not follow peripheral");
	chk_input_released: assert property (@(posedge clk) disable iff (rst)
		!$past(drive_enable) && !$past(func_active) |-> !pad_oe)
		else $error("input pin still driven");
endmodule
`default_nettype wire

// File: dv/gpcp_pins_model.sv
`default_nettype none
// ----------------------------------------
// Board side of the pins
// ----------------------------------------
module gpcp_pins_model (
	input wire logic [7:0] pad_out,
	input wire logic [7:0] pad_oe,
	input wire logic [7:0] high_bias,
	input wire logic [7:0] low_bias,
	input wire logic [7:0] ext_level,
	output logic [7:0] pad_in
);
	timeunit 1ns;
	timeprecision 1ns;
	// Bias only wins while the pin is not driven, as on a real board
	always_comb begin
		for (int i = 0; i < 8; i++) begin
			pad_in[i] = pad_oe[i] ? pad_out[i] :
				high_bias[i] ? 1'b1 : low_bias[i] ? 1'b0 : ext_level[i];
		end
	end
endmodule
`default_nettype wire

// File: dv/gpcp_port_tb.sv
`default_nettype none
`define CHK(nm, ex, got) begin samples_checked++; if ((got) !== (ex)) begin mismatches++; \
	$display("unexpected %s expected %h seen %h", nm, ex, got); end end
module gpcp_port_tb;
	import gpcp_pkg::*;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk = 0, rst = 1, avs_read = 0, avs_write = 0, sel_a = 0;
	logic [5:0] avs_address = '0;
	logic [31:0] avs_writedata = '0, rd, rd_s, rd_a;
	logic [3:0] avs_byteenable = '0;
	logic [1:0] rsp, rsp_s, rsp_a;
	logic ws, wa, rv, rvs, rva;
	logic [31:0] per_o = 32'h00000001, per_e = 32'hFFFFFFFF;
	logic [7:0] ext = 8'hA5, pin_s, pin_a, po, poe, pstr, phb, plb, pao, paoe, astr, ahb, alb;
	int mismatches = 0, samples_checked = 0;
	initial forever #50 clk = ~clk;
	gpcp_port #(.ANALOG(1'b0)) uut (.clk(clk), .rst(rst), .avs_address(avs_address),
		.avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_byteenable(avs_byteenable), .avs_readdata(rd_s), .avs_readdatavalid(rvs),
		.avs_response(rsp_s), .avs_waitrequest(ws), .periph_out(per_o), .periph_oe(per_e),
		.pad_in(pin_s), .pad_out(po), .pad_oe(poe), .pad_strength(pstr),
		.pad_high_bias(phb), .pad_low_bias(plb));
	gpcp_port #(.ANALOG(1'b1)) uut_a (.clk(clk), .rst(rst), .avs_address(avs_address),
		.avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_byteenable(avs_byteenable), .avs_readdata(rd_a), .avs_readdatavalid(rva),
		.avs_response(rsp_a), .avs_waitrequest(wa), .periph_out(per_o), .periph_oe(per_e),
		.pad_in(pin_a), .pad_out(pao), .pad_oe(paoe), .pad_strength(astr),
		.pad_high_bias(ahb), .pad_low_bias(alb));
	gpcp_pins_model brd_s (.pad_out(po), .pad_oe(poe), .high_bias(phb), .low_bias(plb),
		.ext_level(ext), .pad_in(pin_s));
	gpcp_pins_model brd_a (.pad_out(pao), .pad_oe(paoe), .high_bias(8'h00),
		.low_bias(8'h00), .ext_level(ext), .pad_in(pin_a));
	// ----------------------------------------
	// Bus access and closing
	// ----------------------------------------
	task automatic finish_test();
		if (mismatches == 0 && samples_checked > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask
	// One edge passes first so a released strobe is never re-raised in the same step
	task automatic bus(input logic wr, input logic [5:0] a, input logic [31:0] d,
		input logic [3:0] be);
		int n;
		n = 0;
		@(posedge clk);
		avs_address <= a;
		avs_writedata <= d;
		avs_byteenable <= be;
		avs_write <= wr;
		avs_read <= !wr;
		do begin
			@(posedge clk);
			n++;
		end while ((sel_a ? wa : ws) !== 1'b0 && n < 20);
		if (n >= 20) begin
			mismatches++;
			finish_test();
		end
		rd = sel_a ? rd_a : rd_s;
		rsp = sel_a ? rsp_a : rsp_s;
		rv = sel_a ? rva : rvs;
		avs_write <= 1'b0;
		avs_read <= 1'b0;
	endtask
	task automatic rchk(input logic [5:0] a, input logic [31:0] ex, input logic [1:0] er);
		bus(1'b0, a, '0, 4'hF);
		`CHK("readdata", ex, rd)
		`CHK("response", er, rsp)
		`CHK("readdatavalid", 1'b1, rv)
	endtask
	task automatic wr(input logic [5:0] a, input logic [31:0] d, input logic [3:0] be);
		bus(1'b1, a, d, be);
		repeat (3) @(posedge clk);
	endtask
	initial begin
		repeat (5000) @(posedge clk);
		mismatches++;
		finish_test();
	end
	// ----------------------------------------
	// Sequence
	// ----------------------------------------
	initial begin
		repeat (3) @(posedge clk);
		rst <= 1'b0;
		// Standard port: only the receive gate offset is unmapped; level shows the board
		for (int i = 0; i < 8; i++) begin
			rchk(6'(4 * i), (i == 5) ? {24'h0, ext} : 32'h0,
				(i == 6) ? RESP_DECODEERROR : RESP_OKAY);
		end
		`CHK("pads idle", 16'h0, {poe, pstr})
		sel_a = 1'b1;
		rchk(OFS_STRENGTH, 32'h0, RESP_DECODEERROR);
		rchk(OFS_FUNC_SELECT, 32'h0, RESP_DECODEERROR);
		rchk(OFS_PIN_LEVEL, 32'h0, RESP_OKAY);
		wr(OFS_RECEIVE_GATE, 32'hFF, 4'h1);
		rchk(OFS_PIN_LEVEL, {24'h0, ext}, RESP_OKAY);
		sel_a = 1'b0;
		wr(OFS_OUT_VALUE, 32'h20, 4'h1);
		`CHK("oe before enable", 8'h00, poe)
		wr(OFS_DRIVE_ENABLE, 32'h20, 4'h1);
		`CHK("driven pin", 16'h2020, {poe, po & poe})
		`CHK("analog driven pin", 16'h2020, {paoe, pao & paoe})
		wr(OFS_STRENGTH, 32'hFF, 4'h1);
		`CHK("strength", 8'h20, pstr)
		`CHK("analog extras", 24'h0, {astr, ahb, alb})
		wr(OFS_HIGH_BIAS, 32'h03, 4'h1);
		wr(OFS_LOW_BIAS, 32'h0C, 4'h1);
		`CHK("bias", 16'h030C, {phb, plb})
		rchk(OFS_PIN_LEVEL, 32'hA3, RESP_OKAY);
		wr(OFS_FUNC_SELECT, 32'h0001, 4'h3);
		`CHK("peripheral pin", 16'h2121, {poe, po & poe})
		wr(OFS_FUNC_SELECT, 32'h0002, 4'h3);
		`CHK("second peripheral", 16'h2120, {poe, po & poe})
		wr(OFS_FUNC_SELECT, 32'h0000, 4'h3);
		`CHK("firmware pin", 16'h2020, {poe, po & poe})
		wr(6'h3C, 32'hFF, 4'h1);
		rchk(6'h3C, 32'h0, RESP_DECODEERROR);
		finish_test();
	end
endmodule
`default_nettype wire
